// ---- pkg/dmd_pkg.sv ----
// shared constants, types and helpers of the display host register block
package dmd_pkg;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int BLINK_DIV = 28672;
   localparam int BLINK_HALF = BLINK_DIV / 2;
   localparam int SELFTEST_CYCLES = 262144;
   localparam int CLEAR_TIME_MS = 110;
   localparam int CLEAR_CYCLES = (CLEAR_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ROM_SCAN_STEPS = 1024;
   localparam int PWM_STEPS = 100;

   // ----------------------------------------
   // control word fields and reset values
   // ----------------------------------------
   localparam int CW_BRT_LSB = 0;
   localparam int CW_FLASH = 3;
   localparam int CW_BLINK = 4;
   localparam int CW_RESULT = 5;
   localparam int CW_TEST = 6;
   localparam int CW_CLEAR = 7;
   localparam logic [7:0] CW_RST = 8'h00;
   localparam logic [7:0] PTR_RST = 8'hff;
   localparam logic [7:0] PTR_AFTER_TEST = 8'hff;
   localparam logic [7:0] FLASH_RST = 8'h00;
   localparam logic [7:0] FLASH_CLEARED = 8'hff;
   localparam logic [7:0] SPACE_CODE = 8'h20;
   localparam logic [15:0] CHECKSUM_DEFAULT = 16'h0000;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   localparam logic [1:0] RG_PTR = 2'b00;
   localparam logic [1:0] RG_GLYPH = 2'b01;
   localparam logic [1:0] RG_CTRL = 2'b10;
   localparam logic [1:0] RG_CHAR = 2'b11;
   localparam logic [2:0] ROW_UNUSED = 3'h7;
   localparam int GLYPH_DOT_MSB = 4;
   localparam int SLOT_MSB = 3;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef struct packed {
      logic cs_n;
      logic wr_n;
      logic rd_n;
      logic attr_sel;
      logic [4:0] addr;
      logic [7:0] data;
   } dmd_pins_t;

   typedef struct packed {
      logic valid;
      logic [7:0] code;
   } dmd_fill_t;

   typedef struct packed {
      logic active;
      logic inverse;
   } dmd_pattern_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CLEAR = 2'b01,
      ST_TEST = 2'b10
   } dmd_state_t;

   function automatic logic [6:0] dmd_duty(input logic [2:0] code);
      case (code)
         3'h0: dmd_duty = 7'h64;
         3'h1: dmd_duty = 7'h50;
         3'h2: dmd_duty = 7'h35;
         3'h3: dmd_duty = 7'h28;
         3'h4: dmd_duty = 7'h1b;
         3'h5: dmd_duty = 7'h14;
         3'h6: dmd_duty = 7'h0d;
         default: dmd_duty = 7'h00;
      endcase
   endfunction

   function automatic logic [6:0] dmd_glyph_addr(input logic [3:0] slot, input logic [2:0] row);
      dmd_glyph_addr = {slot, row};
   endfunction

endpackage

// ---- design/dmd_glyph_mem.sv ----
// custom glyph dot storage: one write port, two registered read ports
`timescale 1ns/1ps
module dmd_glyph_mem (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic wr_en_i,
   input wire logic [6:0] wr_addr_i,
   input wire logic [4:0] wr_data_i,
   input wire logic [6:0] rda_addr_i,
   output logic [4:0] rda_data_o,
   input wire logic [6:0] rdb_addr_i,
   output logic [4:0] rdb_data_o
);
   // array has no reset; glyphs survive a display reset
   logic [4:0] mem_q [0:127];

   always_ff @(posedge core_clk_i) begin
      if (wr_en_i) begin
         mem_q[wr_addr_i] <= wr_data_i;
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rda_data_o <= 5'h00;
         rdb_data_o <= 5'h00;
      end else begin
         rda_data_o <= mem_q[rda_addr_i];
         rdb_data_o <= mem_q[rdb_addr_i];
      end
   end
endmodule

// ---- design/dmd_host_regs.sv ----
// host register bank of the eight-character dot-matrix display
`timescale 1ns/1ps
// What this block does
// - glyph slot pointer is 8 bits; low four bits pick one of 16 slots
// - glyph row index from address 2:0, dots from data 4:0, data 7:5 ignored
// - data bit 0 is rightmost column, data bit 4 leftmost column
// - attribute select high, A4 low: A3 low pointer, A3 high glyph rows
// - flash attribute memory: one bit per character, address 2:0, A3-A4 ignored
// - flash attribute write: data bit 0 one sets, zero clears
// - flash enable plus attribute flashes character at clock over 28,672
// - flash enable zero makes attribute memory ignored
// - control word is eight bits, every write updates all bits but bit 5
// - bits 2:0 set brightness duty; 000 full, 111 blank
// - blink bit blinks all eight characters at clock over 28,672
// - whole-display blink overrides per-character flash
// - bit 6 starts self-test; bit 5 read-only pass result
// - self-test checksums decoder ROM outputs; pass only on match
// - self-test shows checkerboard then inverse on the LEDs
// - self-test lasts 262,144 clock periods
// - after self-test: blanks, control zeroed but bit 5, flash cleared, pointer ones
// - bit 7 starts clear unless bit 6 is also set; device returns bit 7 to zero when done
// - clear loads spaces, flash memory ones; glyphs, pointer, other bits kept
// - character bit 7 clear selects ROM code, set selects glyph slot 3:0
module dmd_host_regs #(
   parameter int BLINK_HALF_CYCLES = dmd_pkg::BLINK_HALF,
   parameter int SELFTEST_LEN = dmd_pkg::SELFTEST_CYCLES,
   parameter int CLEAR_LEN = dmd_pkg::CLEAR_CYCLES,
   parameter logic [15:0] CHECKSUM_EXPECTED = dmd_pkg::CHECKSUM_DEFAULT
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic cs_n_i,
   input wire logic wr_n_i,
   input wire logic rd_n_i,
   input wire logic attribute_select_i,
   input wire logic [4:0] addr_i,
   input wire logic [7:0] data_i,
   output logic [7:0] data_o,
   output logic data_oe_o,
   input wire logic [7:0] scan_char_i,
   input wire logic [2:0] scan_row_i,
   output logic [6:0] rom_code_o,
   output logic [2:0] rom_row_o,
   input wire logic [4:0] rom_dots_i,
   output logic [4:0] scan_dots_o,
   output logic [7:0] char_lit_o,
   output dmd_pkg::dmd_pattern_t test_pattern_o,
   output dmd_pkg::dmd_fill_t char_fill_o,
   output logic busy_o
);
   import dmd_pkg::*;
   // ----------------------------------------
   // pin synchroniser and strobe decode
   // ----------------------------------------
   dmd_pins_t pins_raw;
   dmd_pins_t pins_m_q;
   dmd_pins_t pins_q;
   dmd_pins_t lat_q;
   logic wr_act;
   logic rd_act;
   logic wr_act_q;
   logic commit;
   dmd_state_t state_q;
   assign pins_raw = '{cs_n: cs_n_i, wr_n: wr_n_i, rd_n: rd_n_i,
                       attr_sel: attribute_select_i, addr: addr_i, data: data_i};
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pins_m_q <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, attr_sel: 1'b0, addr: 5'h00, data: 8'h00};
         pins_q <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, attr_sel: 1'b0, addr: 5'h00, data: 8'h00};
      end else begin
         pins_m_q <= pins_raw;
         pins_q <= pins_m_q;
      end
   end
   // both strobes low or both high do nothing
   assign wr_act = ~pins_q.cs_n & ~pins_q.wr_n & pins_q.rd_n;
   assign rd_act = ~pins_q.cs_n & pins_q.wr_n & ~pins_q.rd_n;
   // commit at end of strobe, using the last sample taken while it was low
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wr_act_q <= 1'b0;
         lat_q <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, attr_sel: 1'b0, addr: 5'h00, data: 8'h00};
      end else begin
         wr_act_q <= wr_act;
         if (wr_act) begin
            lat_q <= pins_q;
         end
      end
   end
   // writes while busy are dropped; the host is not to issue them anyway
   assign commit = wr_act_q & ~wr_act & (state_q == ST_IDLE);
   function automatic logic [1:0] region(input logic [4:0] a);
      region = {a[4], a[3]};
   endfunction
   logic wr_ptr;
   logic wr_glyph;
   logic wr_ctrl;
   logic wr_flash;
   assign wr_ptr = commit & lat_q.attr_sel & (region(lat_q.addr) == RG_PTR);
   assign wr_glyph = commit & lat_q.attr_sel & (region(lat_q.addr) == RG_GLYPH);
   assign wr_ctrl = commit & lat_q.attr_sel & (region(lat_q.addr) == RG_CTRL);
   assign wr_flash = commit & ~lat_q.attr_sel;

   // ----------------------------------------
   // sequencer: idle, clear, self-test
   // ----------------------------------------
   logic [23:0] clr_cnt_q;
   logic [19:0] tst_cnt_q;
   logic clr_done;
   logic tst_done;
   logic start_test;
   logic start_clear;
   assign start_test = wr_ctrl & lat_q.data[CW_TEST];
   assign start_clear = wr_ctrl & lat_q.data[CW_CLEAR] & ~lat_q.data[CW_TEST];
   assign clr_done = (state_q == ST_CLEAR) && (clr_cnt_q == 24'(CLEAR_LEN - 1));
   assign tst_done = (state_q == ST_TEST) && (tst_cnt_q == 20'(SELFTEST_LEN - 1));
   assign busy_o = (state_q != ST_IDLE);
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (start_test) begin
                  state_q <= ST_TEST;
               end else if (start_clear) begin
                  state_q <= ST_CLEAR;
               end
            end
            ST_CLEAR: begin
               if (clr_done) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_TEST: begin
               if (tst_done) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         clr_cnt_q <= 24'h000000;
      end else if (state_q == ST_CLEAR) begin
         clr_cnt_q <= clr_cnt_q + 24'h000001;
      end else begin
         clr_cnt_q <= 24'h000000;
      end
   end
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tst_cnt_q <= 20'h00000;
      end else if (state_q == ST_TEST) begin
         tst_cnt_q <= tst_cnt_q + 20'h00001;
      end else begin
         tst_cnt_q <= 20'h00000;
      end
   end

   // ----------------------------------------
   // self-test: decoder ROM checksum, then LED patterns
   // ----------------------------------------
   logic rom_phase;
   logic sum_vld_q;
   logic [15:0] sum_q;
   logic result_q;
   logic [4:0] rom_dots_q;
   // row 7 does not exist, so its steps add nothing
   assign rom_phase = (state_q == ST_TEST) && (tst_cnt_q < 20'(ROM_SCAN_STEPS));
   assign rom_code_o = rom_phase ? tst_cnt_q[9:3] : scan_char_i[6:0];
   assign rom_row_o = rom_phase ? tst_cnt_q[2:0] : scan_row_i;
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rom_dots_q <= 5'h00;
         sum_vld_q <= 1'b0;
         sum_q <= 16'h0000;
      end else begin
         rom_dots_q <= rom_dots_i;
         sum_vld_q <= rom_phase && (tst_cnt_q[2:0] != ROW_UNUSED);
         if (start_test) begin
            sum_q <= 16'h0000;
         end else if (sum_vld_q) begin
            sum_q <= sum_q + {11'h000, rom_dots_q};
         end
      end
   end
   // verdict taken once the checksum pipeline has drained
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         result_q <= 1'b0;
      end else if ((state_q == ST_TEST) && (tst_cnt_q == 20'(ROM_SCAN_STEPS + 1))) begin
         result_q <= (sum_q == CHECKSUM_EXPECTED);
      end
   end
   // pattern drops with busy, so it never outlives the test
   logic pat_on;
   assign pat_on = (state_q == ST_TEST) && !rom_phase && !tst_done;
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         test_pattern_o <= '{active: 1'b0, inverse: 1'b0};
      end else begin
         test_pattern_o.active <= pat_on;
         test_pattern_o.inverse <= pat_on && (tst_cnt_q >= 20'(SELFTEST_LEN / 2));
      end
   end

   // ----------------------------------------
   // glyph slot pointer and control word
   // ----------------------------------------
   logic [7:0] ptr_q;
   logic [7:0] ctrl_q;
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ptr_q <= PTR_RST;
      end else if (tst_done) begin
         ptr_q <= PTR_AFTER_TEST;
      end else if (wr_ptr) begin
         ptr_q <= lat_q.data;
      end
   end
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_q <= CW_RST;
      end else if (tst_done) begin
         ctrl_q <= CW_RST;
         ctrl_q[CW_RESULT] <= result_q;
      end else if (clr_done) begin
         ctrl_q[CW_CLEAR] <= 1'b0;
      end else if (wr_ctrl) begin
         ctrl_q <= lat_q.data;
         ctrl_q[CW_RESULT] <= ctrl_q[CW_RESULT];
      end
   end

   // ----------------------------------------
   // flash attribute memory
   // ----------------------------------------
   logic [7:0] flash_q;
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         flash_q <= FLASH_RST;
      end else if (tst_done) begin
         flash_q <= FLASH_RST;
      end else if (clr_done) begin
         flash_q <= FLASH_CLEARED;
      end else if (wr_flash) begin
         flash_q[lat_q.addr[2:0]] <= lat_q.data[0];
      end
   end
   // character memory lives outside; it is told to fill with spaces
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         char_fill_o <= '{valid: 1'b0, code: SPACE_CODE};
      end else begin
         char_fill_o <= '{valid: tst_done | clr_done, code: SPACE_CODE};
      end
   end

   // ----------------------------------------
   // custom glyph memory
   // ----------------------------------------
   logic [4:0] host_dots;
   logic [4:0] glyph_dots;
   logic sel_glyph_q;
   // dot 0 is the rightmost column all the way to the LED drivers
   dmd_glyph_mem u_mem (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .wr_en_i(wr_glyph && (lat_q.addr[2:0] != ROW_UNUSED)),
      .wr_addr_i(dmd_glyph_addr(ptr_q[SLOT_MSB:0], lat_q.addr[2:0])),
      .wr_data_i(lat_q.data[GLYPH_DOT_MSB:0]),
      .rda_addr_i(dmd_glyph_addr(ptr_q[SLOT_MSB:0], pins_q.addr[2:0])),
      .rda_data_o(host_dots),
      .rdb_addr_i(dmd_glyph_addr(scan_char_i[SLOT_MSB:0], scan_row_i)),
      .rdb_data_o(glyph_dots)
   );
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sel_glyph_q <= 1'b0;
      end else begin
         sel_glyph_q <= scan_char_i[7];
      end
   end
   // rom dots registered so both sources carry one cycle of latency
   assign scan_dots_o = sel_glyph_q ? glyph_dots : rom_dots_q;
   // ----------------------------------------
   // host read path
   // ----------------------------------------
   logic [7:0] rd_val;
   always_comb begin
      rd_val = 8'h00;
      if (!pins_q.attr_sel) begin
         rd_val = {7'h00, flash_q[pins_q.addr[2:0]]};
      end else begin
         case (region(pins_q.addr))
            RG_PTR: rd_val = ptr_q;
            RG_GLYPH: rd_val = (pins_q.addr[2:0] == ROW_UNUSED) ? 8'h00 : {3'h0, host_dots};
            RG_CTRL: rd_val = ctrl_q;
            default: rd_val = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         data_o <= 8'h00;
      end else if (rd_act) begin
         data_o <= rd_val;
      end
   end
   assign data_oe_o = rd_act;
   // ----------------------------------------
   // brightness, flash and blink
   // ----------------------------------------
   logic [6:0] pwm_q;
   logic [15:0] blink_cnt_q;
   logic phase_q;
   logic bright_on;
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pwm_q <= 7'h00;
      end else if (pwm_q == 7'(PWM_STEPS - 1)) begin
         pwm_q <= 7'h00;
      end else begin
         pwm_q <= pwm_q + 7'h01;
      end
   end

   assign bright_on = (pwm_q < dmd_duty(ctrl_q[CW_BRT_LSB +: 3]));

   // one phase toggle per half period gives clock over 28,672 overall
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         blink_cnt_q <= 16'h0000;
         phase_q <= 1'b1;
      end else if (blink_cnt_q == 16'(BLINK_HALF_CYCLES - 1)) begin
         blink_cnt_q <= 16'h0000;
         phase_q <= ~phase_q;
      end else begin
         blink_cnt_q <= blink_cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         char_lit_o <= 8'h00;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (test_pattern_o.active) begin
               char_lit_o[i] <= 1'b1;
            end else if (ctrl_q[CW_BLINK]) begin
               char_lit_o[i] <= bright_on & phase_q;
            end else if (ctrl_q[CW_FLASH] && flash_q[i]) begin
               char_lit_o[i] <= bright_on & phase_q;
            end else begin
               char_lit_o[i] <= bright_on;
            end
         end
      end
   end
endmodule

// ---- testbench/dmd_host_regs_checker.sv ----
// assertion checker for the display host register block
`timescale 1ns/1ps
module dmd_host_regs_checker #(
   parameter int SELFTEST_LEN = 262144,
   parameter int CLEAR_LEN = 3
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic cs_n_i,
   input wire logic wr_n_i,
   input wire logic rd_n_i,
   input wire logic data_oe_o,
   input wire logic [7:0] scan_char_i,
   input wire logic [2:0] scan_row_i,
   input wire logic [6:0] rom_code_o,
   input wire logic [2:0] rom_row_o,
   input wire logic [4:0] rom_dots_i,
   input wire logic [4:0] scan_dots_o,
   input wire dmd_pkg::dmd_pattern_t test_pattern_o,
   input wire dmd_pkg::dmd_fill_t char_fill_o,
   input wire logic busy_o
);
   import dmd_pkg::*;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   logic [31:0] run_q;
   logic rd_req;
   assign rd_req = !cs_n_i && !rd_n_i && wr_n_i;
   // length of the current busy run, so the end can be checked exactly
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         run_q <= 32'h0;
      end else if (busy_o) begin
         run_q <= run_q + 32'h1;
      end else begin
         run_q <= 32'h0;
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_rd_press;
      $fell(rd_n_i) && !cs_n_i && wr_n_i;
   endsequence
   sequence s_busy_end;
      busy_o ##1 !busy_o;
   endsequence
   // ----------------------------------------
   // properties
   // ----------------------------------------
   a_oe_start: assert property (s_rd_press |-> ##[2:3] data_oe_o)
      else $error("bus drive late after read strobe");
   a_oe_cause: assert property (data_oe_o |-> $past(rd_req, 2))
      else $error("bus driven without a read");
   a_oe_drop: assert property ($rose(rd_n_i) |-> ##[1:3] !data_oe_o)
      else $error("bus still driven after read");
   a_fill_space: assert property (char_fill_o.valid |-> char_fill_o.code == SPACE_CODE)
      else $error("fill code not a space");
   a_fill_single: assert property (char_fill_o.valid |=> !char_fill_o.valid)
      else $error("fill pulse too long");
   a_fill_at_end: assert property ($rose(char_fill_o.valid) |-> $past(busy_o))
      else $error("fill pulse without a clear or test");
   a_busy_span: assert property (s_busy_end |-> (run_q == CLEAR_LEN || run_q == SELFTEST_LEN))
      else $error("busy run of wrong length");
   a_pattern_busy: assert property (test_pattern_o.active |-> busy_o)
      else $error("test pattern outside self-test");
   a_inverse_only: assert property (test_pattern_o.inverse |-> test_pattern_o.active)
      else $error("inverse pattern without pattern");
   a_rom_follow: assert property (!busy_o |-> rom_code_o == scan_char_i[6:0] && rom_row_o == scan_row_i)
      else $error("decoder address not from scan");
   a_rom_dots: assert property (!busy_o && !scan_char_i[7] |=> scan_dots_o == $past(rom_dots_i))
      else $error("decoder dots not passed on");
endmodule

bind dmd_host_regs dmd_host_regs_checker #(.SELFTEST_LEN(SELFTEST_LEN), .CLEAR_LEN(CLEAR_LEN)) chk_u (
   .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i), .wr_n_i(wr_n_i), .rd_n_i(rd_n_i),
   .data_oe_o(data_oe_o), .scan_char_i(scan_char_i), .scan_row_i(scan_row_i), .rom_code_o(rom_code_o),
   .rom_row_o(rom_row_o), .rom_dots_i(rom_dots_i), .scan_dots_o(scan_dots_o),
   .test_pattern_o(test_pattern_o), .char_fill_o(char_fill_o), .busy_o(busy_o));

// ---- testbench/dmd_host_model.sv ----
// host processor model driving the display's parallel bus pins
`timescale 1ns/1ps
module dmd_host_model (
   input wire logic core_clk_i,
   input wire logic busy_i,
   input wire logic [7:0] rdata_i,
   output dmd_pkg::dmd_pins_t pins_o
);
   import dmd_pkg::*;
   initial begin
      pins_o = '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, attr_sel: 1'b1, addr: 5'h00, data: 8'h5a};
   end
   // ----------------------------------------
   // one bus cycle, strobes held past the two-flop sync
   // ----------------------------------------
   task automatic access(input logic wr, input logic attr, input logic [4:0] a,
         input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      // never touch the bus while a clear or self-test runs
      while (busy_i !== 1'b0 && n < 4000) begin
         @(negedge core_clk_i);
         n++;
      end
      pins_o.attr_sel = attr;
      pins_o.addr = a;
      pins_o.data = wr ? d : ~pins_o.data;
      pins_o.cs_n = 1'b0;
      pins_o.wr_n = ~wr;
      pins_o.rd_n = wr;
      repeat (5) @(negedge core_clk_i);
      q = rdata_i;
      pins_o.cs_n = 1'b1;
      pins_o.wr_n = 1'b1;
      pins_o.rd_n = 1'b1;
      // released bus shows the inverse, not a stale value
      pins_o.data = ~pins_o.data;
      repeat (5) @(negedge core_clk_i);
   endtask
endmodule

// ---- testbench/test_dmd_host_regs.sv ----
// self-checking bench of the display host register block
`timescale 1ns/1ps
module test_dmd_host_regs;
   import dmd_pkg::*;
   // ----------------------------------------
   // setup
   // ----------------------------------------
   localparam int SELF_LEN = 2048;
   // decoder model below sums to this over codes 0..127, rows 0..6
   localparam logic [15:0] SUM_OK = 16'h3640;
   localparam logic [4:0] GLYPH [7] = '{5'h1f, 5'h10, 5'h10, 5'h1e, 5'h10, 5'h10, 5'h10};
   localparam int DUTY [8] = '{100, 80, 53, 40, 27, 20, 13, 0};
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] scan_char_i = 8'h85;
   logic [2:0] scan_row_i = 3'h0;
   dmd_pins_t pins;
   logic [7:0] data_o, char_lit_o, q, lo, hi;
   logic [6:0] rom_code_o;
   logic [2:0] rom_row_o;
   logic [4:0] rom_dots_i, scan_dots_o;
   logic data_oe_o, busy_o, seen_fill, seen_pat;
   // forces dot 0 on, so the checksum no longer matches
   logic rom_bad = 1'b0;
   dmd_pattern_t test_pattern_o;
   dmd_fill_t char_fill_o;
   int errors = 0;
   int n_tests = 0;
   int cnt, mix, n;
   `define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin errors++; \
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got); end end

   always #20 core_clk_i = ~core_clk_i;
   assign rom_dots_i = (rom_code_o[4:0] ^ {2'b00, rom_row_o}) | {4'h0, rom_bad};
   always @(posedge core_clk_i) begin
      if (char_fill_o.valid === 1'b1) seen_fill = 1'b1;
      if (test_pattern_o.active === 1'b1) seen_pat = 1'b1;
   end

   dmd_host_model host_u (.core_clk_i(core_clk_i), .busy_i(busy_o), .rdata_i(data_o), .pins_o(pins));
   dmd_host_regs #(.BLINK_HALF_CYCLES(8), .SELFTEST_LEN(SELF_LEN), .CLEAR_LEN(3), .CHECKSUM_EXPECTED(SUM_OK)) dut_u (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(pins.cs_n), .wr_n_i(pins.wr_n),
      .rd_n_i(pins.rd_n), .attribute_select_i(pins.attr_sel), .addr_i(pins.addr), .data_i(pins.data),
      .data_o(data_o), .data_oe_o(data_oe_o), .scan_char_i(scan_char_i), .scan_row_i(scan_row_i),
      .rom_code_o(rom_code_o), .rom_row_o(rom_row_o), .rom_dots_i(rom_dots_i), .scan_dots_o(scan_dots_o),
      .char_lit_o(char_lit_o), .test_pattern_o(test_pattern_o), .char_fill_o(char_fill_o), .busy_o(busy_o));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic wr(input logic attr, input logic [4:0] a, input logic [7:0] d);
      host_u.access(1'b1, attr, a, d, q);
   endtask
   task automatic rd(input logic attr, input logic [4:0] a);
      host_u.access(1'b0, attr, a, 8'h00, q);
   endtask
   // and/or of the enables plus lit count of one character
   task automatic watch(input int len, input int b);
      lo = 8'hff;
      hi = 8'h00;
      cnt = 0;
      mix = 0;
      repeat (len) begin
         @(negedge core_clk_i);
         lo = lo & char_lit_o;
         hi = hi | char_lit_o;
         cnt += int'(char_lit_o[b]);
         mix += int'(char_lit_o != 8'h00 && char_lit_o != 8'hff);
      end
   endtask
   task automatic wait_idle();
      n = 0;
      while (busy_o !== 1'b0 && n < 4000) begin
         @(negedge core_clk_i);
         n++;
      end
      `CHK("busy", 1'b0, busy_o)
   endtask
   task automatic complete_run();
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ----------------------------------------
   // sequence of tests
   // ----------------------------------------
   initial begin
      seen_fill = 1'b0;
      seen_pat = 1'b0;
      repeat (6) @(negedge core_clk_i);
      sys_rst_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      rd(1'b1, 5'h10);
      `CHK("ctrl rst", 8'h00, q)
      rd(1'b1, 5'h00);
      `CHK("ptr rst", 8'hff, q)
      // junk in the unused data bits must not matter
      wr(1'b1, 5'h00, 8'hf5);
      rd(1'b1, 5'h00);
      `CHK("ptr slot", 4'h5, q[3:0])
      for (int r = 0; r < 7; r++) wr(1'b1, 5'h08 | 5'(r), {3'b111, GLYPH[r]});
      for (int r = 0; r < 7; r++) begin
         rd(1'b1, 5'h08 | 5'(r));
         `CHK("row rd", GLYPH[r], q[4:0])
         scan_row_i = 3'(r);
         @(negedge core_clk_i);
         `CHK("row dots", GLYPH[r], scan_dots_o)
      end
      scan_char_i = 8'h4b;
      @(negedge core_clk_i);
      `CHK("rom dots", 5'h0d, scan_dots_o)
      scan_char_i = 8'h85;
      for (int k = 0; k < 8; k++) begin
         wr(1'b1, 5'h10, 8'(k));
         watch(100, 0);
         `CHK("duty", DUTY[k], cnt)
      end
      wr(1'b0, 5'h1a, 8'hff);
      wr(1'b0, 5'h03, 8'hfe);
      wr(1'b1, 5'h10, 8'h00);
      watch(32, 2);
      `CHK("flash off", 8'hff, lo)
      wr(1'b1, 5'h10, 8'h08);
      watch(32, 2);
      `CHK("flash lo", 8'hfb, lo)
      `CHK("flash rate", 16, cnt)
      wr(1'b1, 5'h10, 8'h18);
      watch(32, 0);
      `CHK("blink rate", 16, cnt)
      `CHK("blink mix", 0, mix)
      seen_fill = 1'b0;
      wr(1'b1, 5'h10, 8'ha1);
      wait_idle();
      rd(1'b1, 5'h10);
      `CHK("ctrl clear", 8'h01, q)
      `CHK("fill clear", 1'b1, seen_fill)
      rd(1'b1, 5'h00);
      `CHK("ptr kept", 4'h5, q[3:0])
      wr(1'b0, 5'h0b, 8'hfe);
      wr(1'b1, 5'h10, 8'h08);
      watch(32, 3);
      `CHK("flash ones", 8'h08, lo)
      `CHK("flash clr", 32, cnt)
      `CHK("glyph kept", GLYPH[6], scan_dots_o)
      seen_fill = 1'b0;
      wr(1'b1, 5'h10, 8'h40);
      wait_idle();
      rd(1'b1, 5'h10);
      `CHK("test result", 8'h20, q)
      rd(1'b1, 5'h00);
      `CHK("ptr ones", 8'hff, q)
      `CHK("pattern", 1'b1, seen_pat)
      `CHK("fill test", 1'b1, seen_fill)
      wr(1'b1, 5'h10, 8'h08);
      watch(32, 2);
      `CHK("flash zero", 8'hff, lo)
      rom_bad = 1'b1;
      wr(1'b1, 5'h10, 8'h40);
      wait_idle();
      rd(1'b1, 5'h10);
      `CHK("test fail", 8'h00, q)
      complete_run();
   end

   // the tests need about 5500 clocks; stop a hang well beyond that
   initial begin
      #(40 * 20000);
      errors++;
      $display("[FAIL] watchdog expected done seen hang");
      complete_run();
   end
endmodule
